// File: design/dsp_datapath.sv
`timescale 1ns/1ps
// Function
// - Conditional real load writes only when true
// - Conditional integer load writes only when true
// - Locked loads signal interlock while loading
// - Locked stores signal interlock while storing
// - Real results go to registers zero-seven
// - Eight auxiliary registers serve as pointers
// - Immediate addresses are 24 bits wide
// - Add with carry sums operands plus carry
// - Real and integer add, both forms
// - Arithmetic shift: negative count shifts right
// - Logical shift: negative count shifts right
// - Real to integer conversion, any destination
// - Integer to real conversion, real destination
// - Multiply real and integer, both forms
// - Negates: zero minus source, borrow variant
// - Rotate destination left by one bit
// - Magnitude of source, real or integer
module dsp_datapath (
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 resetn,
  // Instruction issue
  input  wire logic                 issue_valid,
  input  wire dsp_pkg::op_e         op,
  input  wire logic                 three_op,
  input  wire logic [3:0]           dst_idx,
  input  wire logic [3:0]           src1_idx,
  input  wire logic [3:0]           src_idx,
  input  wire logic                 src_from_mem,
  input  wire logic [31:0]          mem_data,
  input  wire logic                 cond_true,
  input  wire logic                 carry_in,
  // Store addressing
  input  wire logic [2:0]           ptr_idx,
  input  wire logic                 use_imm_addr,
  input  wire logic [23:0]          imm_addr,
  // Register write result
  output logic                      wr_en_r,
  output logic      [3:0]           wr_idx_r,
  output logic      [31:0]          wr_data_r,
  // Memory store and interlock
  output logic                      st_valid_r,
  output logic      [23:0]          st_addr_r,
  output logic      [31:0]          st_data_r,
  output logic                      locked_r,
  // Observation port
  input  wire logic [3:0]           rd_idx,
  output logic      [31:0]          rd_data_r
);

  // ==========================================================
  // Register file: ext precision 0-7, aux pointers 8-15
  logic [31:0] regs_r [dsp_pkg::REG_CNT];
  logic [3:0]  dst_eff;
  logic [31:0] a_val;
  logic [31:0] b_val;
  logic [31:0] ptr_val;
  logic [31:0] real_res;
  logic [31:0] res_nxt;
  logic        wen_nxt;
  logic [23:0] st_addr_nxt;

  function automatic logic [31:0] shift_fn(input logic [31:0] v,
                                           input logic [6:0]  cnt,
                                           input logic        arith);
    logic [6:0]  mag;
    logic [31:0] fill;
    fill = (arith && v[31]) ? 32'hFFFF_FFFF : 32'h0000_0000;
    mag = cnt[6] ? 7'(-cnt) : cnt;
    if (!cnt[6]) return (mag > 7'd31) ? 32'h0 : v << mag;
    if (mag > 7'd31) return fill;
    return (v >> mag) | ~(fill >> mag) & fill;
  endfunction

  // ==========================================================
  // Operand selection
  always_comb begin
    dst_eff = dsp_pkg::is_real_dst(op) ? {1'b0, dst_idx[2:0]}
                                      : dst_idx;
    a_val = three_op ? regs_r[src1_idx] : regs_r[dst_eff];
    b_val = src_from_mem ? mem_data : regs_r[src_idx];
    ptr_val = regs_r[dsp_pkg::AUX_BASE + {1'b0, ptr_idx}];
    st_addr_nxt = use_imm_addr ? imm_addr
                               : ptr_val[dsp_pkg::ADDR_W-1:0];
  end

  real_unit u_real (
    .a_val (a_val),
    .b_val (b_val),
    .op    (op),
    .res   (real_res)
  );

  // ==========================================================
  // Result and write enable
  always_comb begin
    res_nxt = b_val;
    wen_nxt = 1'b1;
    case (op)
      dsp_pkg::op_nop:            wen_nxt = 1'b0;
      dsp_pkg::real_load_if:      wen_nxt = cond_true;
      dsp_pkg::int_load_if:       wen_nxt = cond_true;
      dsp_pkg::real_load_locked:  res_nxt = b_val;
      dsp_pkg::int_load_locked:   res_nxt = b_val;
      dsp_pkg::real_store,
      dsp_pkg::real_store_locked,
      dsp_pkg::int_store,
      dsp_pkg::int_store_locked:  wen_nxt = 1'b0;
      dsp_pkg::int_add_carry:     res_nxt = a_val + b_val
                                            + {31'h0, carry_in};
      dsp_pkg::int_add:           res_nxt = a_val + b_val;
      dsp_pkg::real_add:          res_nxt = real_res;
      dsp_pkg::arith_shift:       res_nxt = shift_fn(a_val,
                                            b_val[dsp_pkg::CNT_W-1:0],
                                            1'b1);
      dsp_pkg::logic_shift:       res_nxt = shift_fn(a_val,
                                            b_val[dsp_pkg::CNT_W-1:0],
                                            1'b0);
      dsp_pkg::real_to_int:       res_nxt = real_res;
      dsp_pkg::int_to_real:       res_nxt = real_res;
      dsp_pkg::real_multiply:     res_nxt = real_res;
      dsp_pkg::int_multiply:      res_nxt = 32'(a_val * b_val);
      dsp_pkg::int_negate_borrow: res_nxt = 32'h0 - b_val
                                            - {31'h0, carry_in};
      dsp_pkg::int_negate:        res_nxt = 32'h0 - b_val;
      dsp_pkg::real_negate:       res_nxt = real_res;
      dsp_pkg::rotate_left_one:   res_nxt = {regs_r[dst_idx][30:0],
                                             regs_r[dst_idx][31]};
      dsp_pkg::real_magnitude:    res_nxt = real_res;
      dsp_pkg::int_magnitude:     res_nxt = b_val[31] ? 32'(-b_val)
                                                      : b_val;
      default:                    res_nxt = b_val;
    endcase
  end

  // ==========================================================
  // Register file update
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < dsp_pkg::REG_CNT; i++) begin
        regs_r[i] <= dsp_pkg::WORD_RST;
      end
    end else if (issue_valid && wen_nxt) begin
      regs_r[dst_eff] <= res_nxt;
    end
  end

  // ==========================================================
  // Write result port
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wr_en_r   <= 1'b0;
      wr_idx_r  <= 4'h0;
      wr_data_r <= dsp_pkg::WORD_RST;
    end else begin
      wr_en_r   <= issue_valid && wen_nxt;
      wr_idx_r  <= dst_eff;
      wr_data_r <= res_nxt;
    end
  end

  // ==========================================================
  // Store port and interlock
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_valid_r <= 1'b0;
      st_addr_r  <= 24'h00_0000;
      st_data_r  <= dsp_pkg::WORD_RST;
      locked_r   <= 1'b0;
    end else begin
      st_valid_r <= issue_valid && dsp_pkg::is_store(op);
      st_addr_r  <= st_addr_nxt;
      st_data_r  <= (op inside {dsp_pkg::real_store,
                                dsp_pkg::real_store_locked})
                    ? regs_r[{1'b0, src_idx[2:0]}] : regs_r[src_idx];
      locked_r   <= issue_valid && dsp_pkg::is_locked(op);
    end
  end

  // ==========================================================
  // Observation port
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rd_data_r <= dsp_pkg::WORD_RST;
    end else begin
      rd_data_r <= regs_r[rd_idx];
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  a_cond_real_load: assert property (
    issue_valid && op == dsp_pkg::real_load_if && cond_true
    |=> wr_en_r && wr_data_r == $past(b_val) && wr_idx_r < dsp_pkg::EXT_CNT)
    else $error("conditional real load did not write");

  a_cond_real_hold: assert property (
    issue_valid && op == dsp_pkg::real_load_if && !cond_true
    |=> !wr_en_r && regs_r[$past(dst_eff)] == $past(regs_r[dst_eff]))
    else $error("false conditional real load changed state");

  a_cond_int_load: assert property (
    issue_valid && op == dsp_pkg::int_load_if
    |=> wr_en_r == $past(cond_true) && wr_idx_r == $past(dst_idx))
    else $error("conditional integer load enable wrong");

  a_locked_load: assert property (
    issue_valid && op inside {dsp_pkg::int_load_locked,
                              dsp_pkg::real_load_locked}
    |=> locked_r && wr_en_r && !st_valid_r && wr_data_r == $past(b_val))
    else $error("locked load without interlock or data");

  a_locked_store: assert property (
    issue_valid && op == dsp_pkg::int_store_locked
    |=> locked_r && st_valid_r && !wr_en_r
        && st_data_r == $past(regs_r[src_idx]))
    else $error("locked store without interlock or data");

  a_real_dst_range: assert property (
    issue_valid && dsp_pkg::is_real_dst(op) |=> wr_idx_r[3] == 1'b0)
    else $error("real result outside ext precision registers");

  a_aux_pointer: assert property (
    issue_valid && dsp_pkg::is_store(op) && !use_imm_addr
    |=> st_addr_r == $past(ptr_val[23:0]))
    else $error("store address not from aux pointer");

  a_imm_address: assert property (
    issue_valid && dsp_pkg::is_store(op) && use_imm_addr
    |=> st_addr_r == $past(imm_addr))
    else $error("immediate store address wrong");

  a_add_carry: assert property (
    issue_valid && op == dsp_pkg::int_add_carry
    |=> wr_data_r == 32'($past(a_val) + $past(b_val) + $past(carry_in)))
    else $error("add with carry sum wrong");

  a_arith_right_sign: assert property (
    issue_valid && op == dsp_pkg::arith_shift && b_val[6] && a_val[31]
    |=> wr_data_r[31])
    else $error("arithmetic right shift lost sign");

  a_logic_right_zero: assert property (
    issue_valid && op == dsp_pkg::logic_shift && b_val[6:0] == 7'h7F
    |=> wr_data_r == ($past(a_val) >> 1))
    else $error("logical right shift by one wrong");

  a_negate_borrow: assert property (
    issue_valid && op == dsp_pkg::int_negate_borrow
    |=> wr_data_r + $past(b_val) + 32'($past(carry_in)) == 32'h0)
    else $error("negate with borrow wrong");

  a_rotate_one: assert property (
    issue_valid && op == dsp_pkg::rotate_left_one
    |=> wr_data_r == {$past(regs_r[dst_idx][30:0]),
                      $past(regs_r[dst_idx][31])})
    else $error("rotate left by one wrong");

  a_int_add: assert property (
    issue_valid && op == dsp_pkg::int_add
    |=> wr_en_r && wr_data_r == 32'($past(a_val) + $past(b_val)))
    else $error("integer add sum wrong");

  a_int_multiply: assert property (
    issue_valid && op == dsp_pkg::int_multiply
    |=> wr_en_r && wr_data_r == 32'($past(a_val) * $past(b_val)))
    else $error("integer multiply product wrong");

  a_int_negate: assert property (
    issue_valid && op == dsp_pkg::int_negate
    |=> wr_en_r && wr_data_r + $past(b_val) == 32'h0000_0000)
    else $error("integer negate wrong");

  a_int_magnitude: assert property (
    issue_valid && op == dsp_pkg::int_magnitude
    |=> (wr_data_r == $past(b_val) || wr_data_r + $past(b_val) == 32'h0)
        && (!wr_data_r[31] || wr_data_r == dsp_pkg::INT_NEG_SAT))
    else $error("integer magnitude wrong");

  a_arith_left_fill: assert property (
    issue_valid && op == dsp_pkg::arith_shift && b_val[6:0] == 7'h01
    |=> wr_data_r == {$past(a_val[30:0]), 1'b0})
    else $error("arithmetic left shift by one wrong");

  a_int_load_hold: assert property (
    issue_valid && op == dsp_pkg::int_load_if && !cond_true
    |=> regs_r[$past(dst_idx)] == $past(regs_r[dst_idx]))
    else $error("false conditional integer load changed state");

  a_real_store_locked: assert property (
    issue_valid && op == dsp_pkg::real_store_locked
    |=> locked_r && st_valid_r
        && st_data_r == $past(regs_r[{1'b0, src_idx[2:0]}]))
    else $error("locked real store without interlock or data");

  c_locked_load: cover property (
    issue_valid && op == dsp_pkg::int_load_locked ##1 locked_r);
  c_locked_store: cover property (
    issue_valid && op == dsp_pkg::real_store_locked ##1 locked_r);
  c_cond_false: cover property (
    issue_valid && op == dsp_pkg::int_load_if && !cond_true);
  c_shift_right: cover property (
    issue_valid && op == dsp_pkg::arith_shift && b_val[6]);

endmodule

// File: design/dsp_pkg.sv
package dsp_pkg;

  // ==========================================================
  // Widths and register file layout
  localparam int WORD_W    = 32;
  localparam int REG_CNT   = 16;
  localparam int IDX_W     = 4;
  localparam int EXT_IDX_W = 3;
  localparam int ADDR_W    = 24;
  localparam int CNT_W     = 7;
  localparam logic [IDX_W-1:0] EXT_CNT  = 4'h8;
  localparam logic [IDX_W-1:0] AUX_BASE = 4'h8;
  localparam logic [WORD_W-1:0] WORD_RST = 32'h0000_0000;

  // ==========================================================
  // Real number layout: sign, 8-bit biased exponent, 23-bit fraction
  localparam int FRAC_W  = 23;
  localparam int EXP_LSB = 23;
  localparam int EXP_MSB = 30;
  localparam int SIGN_B  = 31;
  localparam int FP_BIAS = 127;
  localparam int EXP_LIM = 254;
  localparam int NORM_LZ = 8;
  localparam logic [WORD_W-1:0] INT_POS_SAT = 32'h7FFF_FFFF;
  localparam logic [WORD_W-1:0] INT_NEG_SAT = 32'h8000_0000;

  // ==========================================================
  // Operations
  typedef enum logic [4:0] {
    op_nop, real_load, real_load_if, real_load_locked,
    int_load, int_load_if, int_load_locked,
    real_store, real_store_locked, int_store, int_store_locked,
    int_add_carry, real_add, int_add, arith_shift, logic_shift,
    real_to_int, int_to_real, real_multiply, int_multiply,
    int_negate_borrow, int_negate, real_negate, rotate_left_one,
    real_magnitude, int_magnitude
  } op_e;

  function automatic logic is_real_dst(input op_e op);
    return op inside {real_load, real_load_if, real_load_locked, real_add,
                      int_to_real, real_multiply, real_negate,
                      real_magnitude};
  endfunction

  function automatic logic is_store(input op_e op);
    return op inside {real_store, real_store_locked, int_store,
                      int_store_locked};
  endfunction

  function automatic logic is_locked(input op_e op);
    return op inside {real_load_locked, int_load_locked, real_store_locked,
                      int_store_locked};
  endfunction

endpackage

// File: design/real_unit.sv
`timescale 1ns/1ps
module real_unit (
  // Operands and selection
  input  wire logic [31:0]    a_val,
  input  wire logic [31:0]    b_val,
  input  wire dsp_pkg::op_e   op,
  // Result
  output logic      [31:0]    res
);

  // ==========================================================
  // Helpers
  function automatic logic [5:0] lead_zero(input logic [31:0] v);
    logic [5:0] n;
    logic       found;
    n = 6'h00;
    found = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      if (!found) begin
        if (v[i]) found = 1'b1;
        else n = n + 6'h01;
      end
    end
    return n;
  endfunction

  function automatic logic [31:0] pack(input logic s, input int e,
                                       input logic [22:0] f);
    if (e <= 0) return dsp_pkg::WORD_RST;
    if (e > dsp_pkg::EXP_LIM) return {s, 8'hFE, 23'h7FFFFF};
    return {s, e[7:0], f};
  endfunction

  function automatic logic [31:0] fp_add(input logic [31:0] x, y);
    logic [31:0] big;
    logic [31:0] sml;
    logic [31:0] m;
    logic [31:0] mb;
    logic [31:0] ms;
    logic [5:0]  lz;
    int          d;
    int          e;
    if (x[30:23] == 8'h00) return y;
    if (y[30:23] == 8'h00) return x;
    big = (x[30:0] >= y[30:0]) ? x : y;
    sml = (x[30:0] >= y[30:0]) ? y : x;
    d = int'(big[30:23]) - int'(sml[30:23]);
    mb = {8'h01, big[22:0]};
    ms = (d > dsp_pkg::FRAC_W + 1) ? 32'h0 : ({8'h01, sml[22:0]} >> d);
    m = (big[31] == sml[31]) ? mb + ms : mb - ms;
    if (m == 32'h0) return dsp_pkg::WORD_RST;
    lz = lead_zero(m);
    e = int'(big[30:23]) + dsp_pkg::NORM_LZ - int'(lz);
    m = (lz < 6'd8) ? (m >> 1) : (m << (lz - 6'd8));
    return pack(big[31], e, m[22:0]);
  endfunction

  function automatic logic [31:0] fp_mul(input logic [31:0] x, y);
    logic [47:0] p;
    logic [22:0] f;
    int          e;
    if (x[30:23] == 8'h00 || y[30:23] == 8'h00) return dsp_pkg::WORD_RST;
    p = {1'b1, x[22:0]} * {1'b1, y[22:0]};
    e = int'(x[30:23]) + int'(y[30:23]) - dsp_pkg::FP_BIAS + int'(p[47]);
    f = p[47] ? p[46:24] : p[45:23];
    return pack(x[31] ^ y[31], e, f);
  endfunction

  function automatic logic [31:0] fp_fix(input logic [31:0] x);
    logic [31:0] mag;
    int          sh;
    sh = int'(x[30:23]) - dsp_pkg::FP_BIAS;
    if (sh < 0) return dsp_pkg::WORD_RST;
    if (sh > 30) return x[31] ? dsp_pkg::INT_NEG_SAT : dsp_pkg::INT_POS_SAT;
    mag = {8'h01, x[22:0]};
    mag = (sh >= dsp_pkg::FRAC_W) ? mag << (sh - dsp_pkg::FRAC_W)
                                  : mag >> (dsp_pkg::FRAC_W - sh);
    return x[31] ? 32'(-mag) : mag;
  endfunction

  function automatic logic [31:0] fp_float(input logic [31:0] v);
    logic [31:0] mag;
    logic [5:0]  lz;
    if (v == 32'h0) return dsp_pkg::WORD_RST;
    mag = v[31] ? 32'(-v) : v;
    lz = lead_zero(mag);
    mag = mag << lz;
    return pack(v[31], dsp_pkg::FP_BIAS + 31 - int'(lz), mag[30:8]);
  endfunction

  // ==========================================================
  // Operation select
  always_comb begin
    case (op)
      dsp_pkg::real_add:       res = fp_add(a_val, b_val);
      dsp_pkg::real_multiply:  res = fp_mul(a_val, b_val);
      dsp_pkg::real_to_int:    res = fp_fix(b_val);
      dsp_pkg::int_to_real:    res = fp_float(b_val);
      dsp_pkg::real_negate:    res = (b_val[30:23] == 8'h00) ? 32'h0
                                     : {~b_val[31], b_val[30:0]};
      dsp_pkg::real_magnitude: res = {1'b0, b_val[30:0]};
      default:                 res = b_val;
    endcase
  end

endmodule

// File: test/dsp_load_store_arith_datapath_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  fails++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module dsp_load_store_arith_datapath_tb;

  // ==========================================================
  // Stimulus and observed signals
  logic            mclk         = 1'b0;
  logic            resetn       = 1'b0;
  logic            issue_valid  = 1'b0;
  dsp_pkg::op_e    op           = dsp_pkg::op_nop;
  logic            three_op     = 1'b0;
  logic [3:0]      dst_idx      = 4'h0;
  logic [3:0]      src1_idx     = 4'h0;
  logic [3:0]      src_idx      = 4'h0;
  logic            src_from_mem = 1'b0;
  logic [31:0]     mem_data     = 32'h0;
  logic            cond_true    = 1'b0;
  logic            carry_in     = 1'b0;
  logic [2:0]      ptr_idx      = 3'h0;
  logic            use_imm_addr = 1'b0;
  logic [23:0]     imm_addr     = 24'h0;
  logic [3:0]      rd_idx       = 4'h0;
  logic            wr_en_r;
  logic [3:0]      wr_idx_r;
  logic [31:0]     wr_data_r;
  logic            st_valid_r;
  logic [23:0]     st_addr_r;
  logic [31:0]     st_data_r;
  logic            locked_r;
  logic [31:0]     rd_data_r;
  logic [31:0]     m [16];
  int              fails           = 0;
  int              samples_checked = 0;

  always #2 mclk = ~mclk;

  dsp_datapath u_dsp_datapath (.mclk, .resetn, .issue_valid, .op,
    .three_op, .dst_idx, .src1_idx, .src_idx, .src_from_mem, .mem_data,
    .cond_true, .carry_in, .ptr_idx, .use_imm_addr, .imm_addr, .wr_en_r,
    .wr_idx_r, .wr_data_r, .st_valid_r, .st_addr_r, .st_data_r,
    .locked_r, .rd_idx, .rd_data_r);

  // ==========================================================
  // Expected result of an operation
  function automatic logic [31:0] calc(dsp_pkg::op_e o, logic [31:0] a,
                                       logic [31:0] b, logic c);
    logic signed [6:0] n;
    int                k;
    n = b[6:0];
    k = (n < 0) ? -n : n;
    case (o)
      dsp_pkg::int_add_carry:     return a + b + {31'h0, c};
      dsp_pkg::int_add:           return a + b;
      dsp_pkg::int_multiply:      return a * b;
      dsp_pkg::arith_shift:
        if (n >= 0) return (k > 31) ? 32'h0 : a << k;
        else return (k > 31) ? {32{a[31]}} : $unsigned($signed(a) >>> k);
      dsp_pkg::logic_shift:
        if (n >= 0) return (k > 31) ? 32'h0 : a << k;
        else return (k > 31) ? 32'h0 : a >> k;
      dsp_pkg::int_negate_borrow: return 32'h0 - b - {31'h0, c};
      dsp_pkg::int_negate:        return 32'h0 - b;
      dsp_pkg::real_negate:       return (b[30:23] == 8'h00) ? 32'h0
                                         : b ^ 32'h8000_0000;
      dsp_pkg::rotate_left_one:   return {a[30:0], a[31]};
      dsp_pkg::int_magnitude:     return b[31] ? 32'h0 - b : b;
      dsp_pkg::real_magnitude:    return b & 32'h7FFF_FFFF;
      default:                    return b;
    endcase
  endfunction

  // ==========================================================
  // One issued operation and its checks
  task automatic do_op(dsp_pkg::op_e o, logic t3, logic [3:0] d,
    logic [3:0] s1, logic [3:0] s, logic fm, logic [31:0] md, logic cnd,
    logic cy, logic [31:0] ov, logic use_ov);
    logic [31:0] a, b, e, sd;
    logic        st, lk, wr, rs;
    logic [23:0] ea;
    rs = o inside {dsp_pkg::real_store, dsp_pkg::real_store_locked};
    st = rs || o inside {dsp_pkg::int_store, dsp_pkg::int_store_locked};
    lk = o inside {dsp_pkg::real_load_locked, dsp_pkg::int_load_locked,
                   dsp_pkg::real_store_locked, dsp_pkg::int_store_locked};
    wr = !st && o != dsp_pkg::op_nop && !(!cnd &&
         o inside {dsp_pkg::real_load_if, dsp_pkg::int_load_if});
    a = t3 ? m[s1] : m[d];
    b = fm ? md : m[s];
    sd = rs ? m[{1'b0, s[2:0]}] : m[s];
    e = use_ov ? ov : calc(o, a, b, cy);
    ea = use_imm_addr ? imm_addr : m[8 + ptr_idx][23:0];
    op = o; three_op = t3; dst_idx = d; src1_idx = s1; src_idx = s;
    src_from_mem = fm; mem_data = md; cond_true = cnd; carry_in = cy;
    issue_valid = 1'b1;
    @(posedge mclk);
    #1;
    `CHK("wr_en", wr, wr_en_r)
    `CHK("locked", lk, locked_r)
    `CHK("st_valid", st, st_valid_r)
    if (wr) begin
      `CHK("wr_idx", d, wr_idx_r)
      `CHK("wr_data", e, wr_data_r)
      m[d] = e;
    end
    if (st) begin
      `CHK("st_addr", ea, st_addr_r)
      `CHK("st_data", sd, st_data_r)
    end
  endtask

  task automatic chk_regs();
    issue_valid = 1'b0;
    for (int i = 0; i < 16; i++) begin
      rd_idx = i[3:0];
      @(posedge mclk);
      #1;
      `CHK("reg", m[i], rd_data_r)
    end
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // Watchdog
  initial begin
    repeat (100000) @(posedge mclk);
    fails++;
    test_done();
  end

  // ==========================================================
  // Main sequence
  dsp_pkg::op_e lst [19] = '{dsp_pkg::int_load, dsp_pkg::int_load_if,
    dsp_pkg::int_load_locked, dsp_pkg::int_store, dsp_pkg::int_store_locked,
    dsp_pkg::real_store, dsp_pkg::real_store_locked, dsp_pkg::int_add_carry,
    dsp_pkg::int_add, dsp_pkg::arith_shift, dsp_pkg::logic_shift,
    dsp_pkg::int_multiply, dsp_pkg::int_negate_borrow, dsp_pkg::int_negate,
    dsp_pkg::rotate_left_one, dsp_pkg::int_magnitude, dsp_pkg::real_load,
    dsp_pkg::real_load_if, dsp_pkg::real_load_locked};
  logic [31:0] cnts [9] = '{32'h0, 32'h1F, 32'h20, 32'h7F, 32'h61,
                            32'h60, 32'h40, 32'h3F, 32'h01};
  initial begin
    dsp_pkg::op_e o;
    logic [3:0]   d;
    logic         t3;
    void'($urandom(48250));
    foreach (m[i]) m[i] = 32'h0;
    repeat (12) @(posedge mclk);
    #1;
    resetn = 1'b1;
    chk_regs();
    for (int i = 0; i < 16; i++)
      do_op(dsp_pkg::int_load, 0, i, 0, 0, 1, $urandom, 1, 0, 0, 0);
    do_op(dsp_pkg::int_load, 0, 3, 0, 0, 1, 32'h8000_0001, 1, 0, 0, 0);
    foreach (cnts[i]) begin
      do_op(dsp_pkg::arith_shift, 1, 4, 3, 0, 1, cnts[i], 1, 0, 0, 0);
      do_op(dsp_pkg::logic_shift, 1, 4, 3, 0, 1, cnts[i], 1, 0, 0, 0);
    end
    use_imm_addr = 1'b1;
    imm_addr = 24'hFFFFFF;
    do_op(dsp_pkg::real_load, 0, 1, 0, 0, 1, 32'h3F80_0000, 1, 0, 0, 0);
    do_op(dsp_pkg::real_load_if, 0, 1, 0, 0, 1, 32'h1234_5678, 0, 0, 0, 0);
    do_op(dsp_pkg::real_load_if, 0, 2, 0, 0, 1, 32'h4040_0000, 1, 0, 0, 0);
    do_op(dsp_pkg::real_add, 1, 3, 1, 1, 0, 0, 1, 0, 32'h4000_0000, 1);
    do_op(dsp_pkg::real_add, 0, 3, 0, 2, 0, 0, 1, 0, 32'h40A0_0000, 1);
    do_op(dsp_pkg::real_multiply, 1, 4, 2, 2, 0, 0, 1, 0, 32'h4110_0000, 1);
    do_op(dsp_pkg::real_multiply, 0, 4, 0, 1, 0, 0, 1, 0, 32'h4110_0000, 1);
    do_op(dsp_pkg::real_to_int, 0, 9, 0, 4, 0, 0, 1, 0, 32'h9, 1);
    do_op(dsp_pkg::int_to_real, 0, 5, 0, 0, 1, 32'h6, 1, 0, 32'h40C0_0000, 1);
    do_op(dsp_pkg::real_negate, 0, 6, 0, 5, 0, 0, 1, 0, 0, 0);
    do_op(dsp_pkg::real_magnitude, 0, 7, 0, 6, 0, 0, 1, 0, 0, 0);
    do_op(dsp_pkg::real_store_locked, 0, 0, 0, 12, 0, 0, 1, 0, 0, 0);
    do_op(dsp_pkg::int_add_carry, 0, 2, 0, 0, 1, 32'hFFFF_FFFF, 1, 1, 0, 0);
    for (int i = 0; i < 600; i++) begin
      o = lst[$urandom_range(18)];
      d = $urandom;
      if (o inside {dsp_pkg::real_load, dsp_pkg::real_load_if,
                    dsp_pkg::real_load_locked}) d[3] = 1'b0;
      t3 = (o == dsp_pkg::rotate_left_one) ? 1'b0 : $urandom;
      ptr_idx = $urandom;
      use_imm_addr = $urandom;
      imm_addr = $urandom;
      do_op(o, t3, d, $urandom, $urandom, $urandom, $urandom, $urandom,
            $urandom, 0, 0);
    end
    chk_regs();
    resetn = 1'b0;
    op = dsp_pkg::int_load;
    issue_valid = 1'b1;
    @(posedge mclk);
    #1;
    `CHK("wr_en_rst", 1'b0, wr_en_r)
    `CHK("rd_rst", 32'h0, rd_data_r)
    resetn = 1'b1;
    foreach (m[i]) m[i] = 32'h0;
    chk_regs();
    test_done();
  end

endmodule
